// ---- core/scr_top.sv ----
`timescale 1ns/100ps
module scr_top #(
    parameter int unsigned WRITE_CYCLES = 16
) (
    // clock and reset
    input  wire logic                          core_clk_i,
    input  wire logic                          reset_n_i,
    // host command stream in
    input  wire logic                          host_valid_i,
    input  wire scr_pkg::scr_packet_t          host_pkt_i,
    output logic                               host_ready_o,
    // host responses out (suppressed during replay)
    input  wire logic                          exec_rsp_valid_i,
    output logic                               host_rsp_valid_o,
    // capture control
    input  wire logic                          capture_begin_request_i,
    input  wire logic                          capture_end_request_i,
    input  wire logic                          capture_commit_request_i,
    output logic                               capturing_o,
    output logic                               commit_busy_o,
    output logic                               commit_skipped_o,
    // command executor
    output logic                               exec_valid_o,
    output scr_pkg::scr_packet_t               exec_pkt_o,
    input  wire logic                          exec_ready_i,
    // user RAM write port
    output scr_pkg::scr_ram_wr_t               ram_wr_o
);
    typedef enum logic [2:0] {
        S_BOOT, S_RFETCH, S_RSEND, S_IDLE, S_CFETCH, S_CCMP, S_CPROG, S_CCNT
    } scr_state_t;

    scr_state_t                    state_r;
    logic                          cap_r;
    logic [scr_pkg::CNT_W-1:0]     cap_cnt_r;
    logic [scr_pkg::CNT_W-1:0]     idx_r;
    logic [2:0]                    byte_r;
    logic                          wr_pend_r;
    logic                          diff_r;
    logic                          skip_r;
    logic                          prog_ok_r;
    scr_pkg::scr_packet_t          cap_mem [scr_pkg::MAX_PACKETS];
    scr_pkg::scr_packet_t          cap_pkt_r;
    scr_pkg::scr_packet_t          wr_pkt_r;
    scr_pkg::scr_packet_t          st_pkt;
    logic [scr_pkg::CNT_W-1:0]     st_count;
    logic                          st_busy;

    wire live_w     = (state_r != S_BOOT) && (state_r != S_RFETCH) && (state_r != S_RSEND);
    wire replay_w   = (state_r == S_RSEND);
    wire cap_full_w = (cap_cnt_r == scr_pkg::CNT_W'(scr_pkg::MAX_PACKETS));
    wire host_fire  = live_w && host_valid_i && exec_ready_i && !wr_pend_r;
    wire cap_fire   = host_fire && cap_r && !cap_full_w;
    wire idle_w     = (state_r == S_IDLE);
    wire commit_w   = idle_w && capture_commit_request_i && !cap_r;
    // program waits a cycle after each index step so the capture read port settles
    wire prog_w     = (state_r == S_CPROG) && prog_ok_r && !st_busy;
    wire cnt_w      = (state_r == S_CCNT) && !st_busy;
    wire last_w     = (idx_r + 9'h001 >= cap_cnt_r);
    wire [7:0] rd_idx_w = idx_r[7:0];

    // host is held off until replay ends; responses of replayed packets dropped
    assign host_ready_o     = live_w && exec_ready_i && !wr_pend_r;
    assign host_rsp_valid_o = exec_rsp_valid_i && live_w;
    assign exec_valid_o     = replay_w || (live_w && host_valid_i && !wr_pend_r);
    assign exec_pkt_o       = replay_w ? st_pkt : host_pkt_i;
    assign capturing_o      = cap_r;
    assign commit_busy_o    = (state_r == S_CFETCH) || (state_r == S_CCMP)
                           || (state_r == S_CPROG) || (state_r == S_CCNT);
    assign commit_skipped_o = skip_r;

    scr_store #(
        .WRITE_CYCLES (WRITE_CYCLES)
    ) u_store (
        .core_clk_i   (core_clk_i),
        .reset_n_i    (reset_n_i),
        .prog_i       (prog_w),
        .prog_idx_i   (rd_idx_w),
        .prog_pkt_i   (cap_pkt_r),
        .prog_cnt_i   (cnt_w),
        .prog_count_i (cap_cnt_r),
        .busy_o       (st_busy),
        .rd_idx_i     (rd_idx_w),
        .rd_pkt_o     (st_pkt),
        .count_o      (st_count)
    );

    // capture memory mirrors the RAM region for compare and program
    always_ff @(posedge core_clk_i) begin
        if (cap_fire) begin
            cap_mem[cap_cnt_r[7:0]] <= host_pkt_i;
        end
        cap_pkt_r <= cap_mem[rd_idx_w];
    end

    // packet bytes go to RAM one per cycle, first byte lowest address
    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            wr_pend_r <= 1'b0;
            byte_r    <= 3'h0;
            wr_pkt_r  <= '0;
            ram_wr_o  <= '0;
        end else begin
            ram_wr_o.wr <= wr_pend_r;
            if (cap_fire) begin
                wr_pend_r     <= 1'b1;
                byte_r        <= 3'h0;
                wr_pkt_r      <= host_pkt_i;
                ram_wr_o.addr <= scr_pkg::CAP_BASE_ADDR
                               + scr_pkg::ADDR_W'({cap_cnt_r[7:0], 3'h0});
            end else if (wr_pend_r) begin
                ram_wr_o.data <= wr_pkt_r.data[8*byte_r +: 8];
                if (byte_r != 3'h0) begin
                    ram_wr_o.addr <= ram_wr_o.addr + 13'h0001;
                end
                byte_r    <= byte_r + 3'h1;
                wr_pend_r <= (byte_r != 3'h7);
            end
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            state_r   <= S_BOOT;
            cap_r     <= 1'b0;
            cap_cnt_r <= '0;
            idx_r     <= '0;
            diff_r    <= 1'b0;
            skip_r    <= 1'b0;
            prog_ok_r <= 1'b0;
        end else begin
            prog_ok_r <= (state_r == S_CPROG) && !prog_w;
            if (idle_w && capture_begin_request_i) begin
                cap_r     <= 1'b1;
                cap_cnt_r <= '0;
            end else if (capture_end_request_i) begin
                cap_r     <= 1'b0;
            end else if (cap_fire) begin
                cap_cnt_r <= cap_cnt_r + 9'h001;
            end
            case (state_r)
                S_BOOT: begin
                    idx_r   <= '0;
                    state_r <= (st_count == '0) ? S_IDLE : S_RFETCH;
                end
                S_RFETCH: state_r <= S_RSEND;
                S_RSEND: begin
                    if (exec_ready_i) begin
                        idx_r   <= idx_r + 9'h001;
                        state_r <= (idx_r + 9'h001 >= st_count) ? S_IDLE : S_RFETCH;
                    end
                end
                S_IDLE: begin
                    if (commit_w) begin
                        idx_r   <= '0;
                        diff_r  <= (cap_cnt_r != st_count);
                        skip_r  <= 1'b0;
                        state_r <= (cap_cnt_r == '0) ? S_CCMP : S_CFETCH;
                    end
                end
                S_CFETCH: state_r <= S_CCMP;
                S_CCMP: begin
                    if (cap_cnt_r != '0 && cap_pkt_r != st_pkt) begin
                        diff_r <= 1'b1;
                    end
                    if (cap_cnt_r == '0 || last_w) begin
                        idx_r  <= '0;
                        skip_r <= !(diff_r || (cap_cnt_r != '0
                                  && cap_pkt_r != st_pkt));
                        state_r <= !(diff_r || (cap_cnt_r != '0 && cap_pkt_r != st_pkt))
                                 ? S_IDLE : ((cap_cnt_r == '0) ? S_CCNT : S_CPROG);
                    end else begin
                        idx_r   <= idx_r + 9'h001;
                        state_r <= S_CFETCH;
                    end
                end
                S_CPROG: begin
                    if (prog_w) begin
                        idx_r   <= idx_r + 9'h001;
                        state_r <= last_w ? S_CCNT : S_CPROG;
                    end
                end
                S_CCNT: if (cnt_w) state_r <= S_IDLE;
                default: state_r <= S_IDLE;
            endcase
        end
    end

    a_no_host_boot: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        !live_w |-> !host_ready_o && !host_rsp_valid_o)
        else $error("host served during replay");
    a_cap_limit: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        cap_cnt_r <= 9'h100)
        else $error("capture count above limit");
    a_cap_region: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        ram_wr_o.wr |-> ram_wr_o.addr >= scr_pkg::CAP_BASE_ADDR)
        else $error("capture write below region");
    a_begin_cap: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        idle_w && capture_begin_request_i |=> cap_r)
        else $error("capture did not start");
    a_end_cap: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        capture_end_request_i && !(idle_w && capture_begin_request_i) |=> !cap_r)
        else $error("capture did not stop");
    a_skip_noprog: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        skip_r && idle_w |-> !prog_w && !cnt_w)
        else $error("flash written on match");
    a_ram_size: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        cap_fire |-> 14'(scr_pkg::CAP_BASE_ADDR) + 14'({cap_cnt_r, 3'h0})
                     + 14'(scr_pkg::PKT_BYTES) <= 14'(scr_pkg::RAM_BYTES))
        else $error("write outside buffer");
    a_replay_whole: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        replay_w && exec_ready_i && (idx_r + 9'h001 < st_count) |=> !host_ready_o)
        else $error("host served before replay end");
    a_commit_refused: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        capture_commit_request_i && cap_r |=> !commit_busy_o)
        else $error("commit taken while capturing");
    a_replay_order: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        replay_w && exec_ready_i |=> idx_r == $past(idx_r) + 9'h001)
        else $error("replay out of order");
    a_replay_mux: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        replay_w |-> exec_valid_o && exec_pkt_o == st_pkt)
        else $error("replay packet not presented");
endmodule : scr_top

// ---- core/scr_pkg.sv ----
package scr_pkg;
    localparam int unsigned RAM_BYTES     = 8192;
    localparam int unsigned CAP_BASE      = 5120;
    localparam int unsigned CAP_BYTES     = 3072;
    localparam int unsigned MAX_PACKETS   = 256;
    localparam int unsigned PKT_BYTES     = 8;
    localparam int unsigned ADDR_W        = 13;
    localparam int unsigned CAP_ADDR_W    = 12;
    localparam int unsigned CNT_W         = 9;
    localparam logic [ADDR_W-1:0] CAP_BASE_ADDR = 13'h1400;

    typedef struct packed {
        logic [PKT_BYTES*8-1:0] data;
    } scr_packet_t;

    typedef struct packed {
        logic              wr;
        logic [ADDR_W-1:0] addr;
        logic [7:0]        data;
    } scr_ram_wr_t;
endpackage : scr_pkg

// ---- core/scr_store.sv ----
`timescale 1ns/100ps
// nonvolatile copy of the startup sequence: one slow write per packet,
// the count is written last, so a reset mid-write replays the old count over partly rewritten packets
module scr_store #(
    parameter int unsigned WRITE_CYCLES = 16
) (
    // clock and reset
    input  wire logic                          core_clk_i,
    input  wire logic                          reset_n_i,
    // program port
    input  wire logic                          prog_i,
    input  wire logic [7:0]                    prog_idx_i,
    input  wire scr_pkg::scr_packet_t          prog_pkt_i,
    input  wire logic                          prog_cnt_i,
    input  wire logic [scr_pkg::CNT_W-1:0]     prog_count_i,
    output logic                               busy_o,
    // read port
    input  wire logic [7:0]                    rd_idx_i,
    output scr_pkg::scr_packet_t               rd_pkt_o,
    output logic [scr_pkg::CNT_W-1:0]          count_o
);
    scr_pkg::scr_packet_t          mem [scr_pkg::MAX_PACKETS];
    logic [scr_pkg::CNT_W-1:0]     count_r = '0;
    logic [15:0]                   wait_r;

    wire start_w = (prog_i || prog_cnt_i) && (wait_r == 16'h0000);
    assign busy_o  = (wait_r != 16'h0000);
    assign count_o = count_r;

    always_ff @(posedge core_clk_i) begin
        if (prog_i && start_w) begin
            mem[prog_idx_i] <= prog_pkt_i;
        end
        rd_pkt_o <= mem[rd_idx_i];
    end

    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            wait_r <= 16'h0000;
        end else if (start_w) begin
            wait_r <= 16'(WRITE_CYCLES);
        end else if (wait_r != 16'h0000) begin
            wait_r <= wait_r - 16'h0001;
        end
    end

    // the stored count survives reset: it stands for flash contents
    always_ff @(posedge core_clk_i) begin
        if (prog_cnt_i && start_w) begin
            count_r <= prog_count_i;
        end
    end
endmodule : scr_store

// ---- test/scr_host_model.sv ----
`timescale 1ns/100ps
// host side: each packet is held until the block takes it or 5000 cycles pass
module scr_host_model (
    input  wire logic           clk_i,
    input  wire logic           ready_i,
    input  wire logic           busy_i,
    output logic                valid_o,
    output scr_pkg::scr_packet_t pkt_o,
    output logic [2:0]          req_o
);
    initial begin
        valid_o = 1'b0;
        pkt_o = '0;
        req_o = 3'h0;
    end
    // sends one packet; valid drops on the rising edge after ready is seen at a falling edge
    task automatic send(input logic [63:0] p);
        int n;
        n = 0;
        @(posedge clk_i);
        valid_o <= 1'b1;
        pkt_o <= p;
        do begin
            @(negedge clk_i);
            n++;
        end while (ready_i !== 1'b1 && n < 5000);
        @(posedge clk_i);
        valid_o <= 1'b0;
        pkt_o <= ~p;
    endtask : send
    task automatic pulse(input int k);
        @(posedge clk_i);
        req_o[k] <= 1'b1;
        @(posedge clk_i);
        req_o[k] <= 1'b0;
    endtask : pulse
    // commit may run long, so the wait is generous but bounded
    task automatic wait_commit(output int c);
        c = 0;
        repeat (3) @(negedge clk_i);
        while (busy_i !== 1'b0 && c < 20000) begin
            @(negedge clk_i);
            c++;
        end
    endtask : wait_commit
endmodule : scr_host_model

// ---- test/scr_top_tb.sv ----
`timescale 1ns/100ps
module scr_top_tb;
    logic                 core_clk_i = 1'b0;
    logic                 reset_n_i = 1'b0;
    logic                 exec_rsp_valid_i = 1'b0;
    logic                 exec_ready_i = 1'b1;
    logic                 host_valid_i, host_ready_o, host_rsp_valid_o, capturing_o;
    logic                 commit_busy_o, commit_skipped_o, exec_valid_o;
    logic [2:0]           req;
    scr_pkg::scr_packet_t host_pkt_i, exec_pkt_o;
    scr_pkg::scr_ram_wr_t ram_wr_o;
    logic [15:0]          lf = 16'h002C;
    logic [63:0]          pk[$], stored[$], exp_exec[$];
    logic [20:0]          exp_ram[$];
    int                   err_count = 0;
    int                   comparisons = 0;
    int                   cap_n, busy_cyc;
    int                   replay_left = 0;
    bit                   cap_on, booting = 1'b1;

    always #20 core_clk_i = ~core_clk_i;

    scr_top #(.WRITE_CYCLES(2)) i_dut (
        .core_clk_i, .reset_n_i, .host_valid_i, .host_pkt_i, .host_ready_o,
        .exec_rsp_valid_i, .host_rsp_valid_o, .capture_begin_request_i(req[0]),
        .capture_end_request_i(req[1]), .capture_commit_request_i(req[2]),
        .capturing_o, .commit_busy_o, .commit_skipped_o, .exec_valid_o,
        .exec_pkt_o, .exec_ready_i, .ram_wr_o
    );
    scr_host_model i_host (
        .clk_i(core_clk_i), .ready_i(host_ready_o), .busy_i(commit_busy_o),
        .valid_o(host_valid_i), .pkt_o(host_pkt_i), .req_o(req)
    );

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr
    always @(posedge core_clk_i) begin
        lf <= lfsr(lf);
        exec_rsp_valid_i <= lf[0];
        exec_ready_i     <= lf[1] | lf[2];
    end

    task automatic check(input logic ok, input string m);
        comparisons++;
        if (ok !== 1'b1) begin
            err_count++;
            $display("wrong value at %0t: %s", $time, m);
        end
    endtask : check
    task automatic tally_and_finish;
        $display("comparisons %0d, errors %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : tally_and_finish
    initial begin
        #(40 * 80000);
        err_count++;
        tally_and_finish();
    end

    // model of what reaches the executor, the user RAM and the host
    always @(negedge core_clk_i) begin
        if (reset_n_i) begin
            check(host_rsp_valid_o === (exec_rsp_valid_i & ~booting), "rsp gate");
            if (booting)
                check(host_ready_o === 1'b0, "host taken in replay");
            if (ram_wr_o.wr === 1'b1)
                check(exp_ram.size() > 0 && {ram_wr_o.addr, ram_wr_o.data} === exp_ram.pop_front(),
                      "ram write");
            if (exec_valid_o === 1'b1 && exec_ready_i === 1'b1) begin
                check(exp_exec.size() > 0 && exec_pkt_o === exp_exec.pop_front(),
                      "exec packet");
                if (booting && replay_left > 0)
                    replay_left--;
            end
            // host side opens on the edge after the last replayed packet
            if (replay_left == 0)
                booting = 1'b0;
        end
    end

    task automatic put(input logic [63:0] p);
        exp_exec.push_back(p);
        if (cap_on && cap_n < scr_pkg::MAX_PACKETS) begin
            for (int k = 0; k < 8; k++)
                exp_ram.push_back({13'(scr_pkg::CAP_BASE + 8 * cap_n + k), p[8*k+:8]});
            stored.push_back(p);
            cap_n++;
        end
        i_host.send(p);
    endtask : put
    task automatic drain;
        repeat (12) @(negedge core_clk_i);
        check(exp_ram.size() == 0 && exp_exec.size() == 0, "missing output");
    endtask : drain
    task automatic capture(input int n);
        i_host.pulse(0);
        cap_on = 1;
        cap_n = 0;
        stored.delete();
        @(negedge core_clk_i);
        check(capturing_o === 1'b1, "capture not on");
        i_host.pulse(2);
        @(negedge core_clk_i);
        check(commit_busy_o === 1'b0, "commit taken while capturing");
        for (int i = 0; i < n; i++)
            put(pk[i]);
        repeat (12) @(negedge core_clk_i);
        i_host.pulse(1);
        cap_on = 0;
        @(negedge core_clk_i);
        check(capturing_o === 1'b0, "capture still on");
    endtask : capture
    task automatic boot;
        @(posedge core_clk_i);
        reset_n_i <= 1'b0;
        booting = 1;
        repeat (2) @(posedge core_clk_i);
        reset_n_i <= 1'b1;
    endtask : boot

    initial begin
        repeat (2) @(posedge core_clk_i);
        reset_n_i <= 1'b1;
        for (int i = 0; i < 257; i++)
            pk.push_back({lf ^ 16'(i * 7919), lfsr(lf ^ 16'(i)), 16'(i), ~lf});
        capture(257);
        put(pk[3]);
        drain();
        i_host.pulse(2);
        i_host.wait_commit(busy_cyc);
        check(busy_cyc > 255 && busy_cyc < 20000 && commit_skipped_o === 1'b0,
              "commit skipped");
        exp_exec = stored;
        replay_left = stored.size();
        boot();
        put(pk[9]);
        drain();
        capture(256);
        drain();
        i_host.pulse(2);
        i_host.wait_commit(busy_cyc);
        check(busy_cyc < 20000 && commit_skipped_o === 1'b1, "identical commit wrote");
        tally_and_finish();
    end
endmodule : scr_top_tb
